// File: src/mfpc_pkg.sv
// constants for the multi-function pin control block
// Summary of operation
// - Each dedicated pin obeys an enabled pull first, then the global tristate, then the function select.
// - While the global tristate bit 13 is set, every audio interface pin and multi-purpose pin is released.
// - A function select acts only with both pulls off and the global tristate clear.
// - Select codes 0 to 9 choose input, divided clock, low, high, lock, temp ok, readback, irq, mic detect, mic short; 10 to 15 are reserved.
// - The first pin-control register holds pin b in bits 15:8 and pin a in bits 7:0 as debounce, irq, pull-up, pull-down, 4-bit select.
// - The second pin-control register holds pin c in bits 7:0 with the same layout.
// - After reset every dedicated pin is a pulled-down input with all other control bits clear.
// - The shared pins have input enables, right at bits 7, 6, 4 and left at bits 3, 2, 0 for debounce, irq and enable.
// - Debounce is bypassed when off and runs only while the master clock runs and the timeout clock enable is 1.
// - All five input pins have debounce and irq masking, and an input event reaches the irq logic only when its irq enable is 1.
// - Only dedicated pins have pulls and output functions; shared pins are inputs only.
// - An 8-bit polarity field, reset 0, inverts right shared (7), left shared (6), pins c, b, a (4, 3, 2); bits 5, 1, 0 reserved.
// - Each input change with its irq enable set is latched into interrupt status bits 4:0; the debounced levels read live at bits 12:8.
package mfpc_pkg;
   localparam int REG_IDX_W = 6;
   // register indexes; byte address is four times the index
   localparam logic [REG_IDX_W-1:0] IDX_AUDIO_IF_CTRL = 6'h09;
   localparam logic [REG_IDX_W-1:0] IDX_PIN_CTRL_AB = 6'h14;
   localparam logic [REG_IDX_W-1:0] IDX_PIN_CTRL_C = 6'h15;
   localparam logic [REG_IDX_W-1:0] IDX_SHARED_CTRL = 6'h16;
   localparam logic [REG_IDX_W-1:0] IDX_INPUT_POL = 6'h17;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_STATUS = 6'h12;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_MASK = 6'h13;
   // field positions
   localparam int TRIS_BIT = 13;
   localparam int PIN_B_LSB = 8;
   localparam int F_DEB = 7;
   localparam int F_IRQ = 6;
   localparam int F_PU = 5;
   localparam int F_PD = 4;
   localparam int SH_R_DEB = 7;
   localparam int SH_R_IRQ = 6;
   localparam int SH_R_EN = 4;
   localparam int SH_L_DEB = 3;
   localparam int SH_L_IRQ = 2;
   localparam int SH_L_EN = 0;
   localparam int POL_R = 7;
   localparam int POL_L = 6;
   localparam int POL_A = 2;
   localparam int STAT_LVL_LSB = 8;
   // reset values
   localparam logic [15:0] RST_AUDIO_IF = 16'h0000;
   localparam logic [15:0] RST_PIN_AB = 16'h1010;
   localparam logic [7:0] RST_PIN_C = 8'h10;
   localparam logic [7:0] RST_SHARED = 8'h00;
   localparam logic [7:0] RST_POL = 8'h00;
   localparam logic [7:0] POL_USED = 8'hDC;
   localparam logic [7:0] SHARED_USED = 8'hDD;
   // pin indexes: a, b, c dedicated; left, right shared
   localparam int NPIN = 5;
   localparam int NDED = 3;
   typedef enum logic [3:0] {
      FN_INPUT = 4'h0,
      FN_CLOCK = 4'h1,
      FN_LOW = 4'h2,
      FN_HIGH = 4'h3,
      FN_PLL_LOCK = 4'h4,
      FN_TEMP_OK = 4'h5,
      FN_READBACK = 4'h6,
      FN_IRQ = 4'h7,
      FN_MIC_DET = 4'h8,
      FN_MIC_SHORT = 4'h9
   } mfpc_func_e;
   // timing
   localparam int CLK_HZ = 10_000_000;
   localparam int DEB_TICK_US = 1000;
   localparam int DEB_TICK_CYC = DEB_TICK_US * (CLK_HZ / 1_000_000);
   localparam int DEB_TICKS = 4;
   localparam int OUT_CLK_DIV = 4;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : mfpc_pkg

// File: src/mfpc_pin_control.sv
// multi-function pin control with AHB-Lite registers and interrupt
`timescale 1ns/100ps
module mfpc_pin_control #(
   parameter int DEB_TICK_CYC = mfpc_pkg::DEB_TICK_CYC,
   parameter int DEB_TICKS = mfpc_pkg::DEB_TICKS,
   parameter int OUT_CLK_DIV = mfpc_pkg::OUT_CLK_DIV
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // dedicated pins a, b, c
   input wire logic [2:0] multiPinIn,
   output logic [2:0] multiPinOut,
   output logic [2:0] multiPinOe,
   output logic [2:0] pinPullupEn,
   output logic [2:0] pinPulldownEn,
   // shared pins left, right
   input wire logic sharedInputLeft,
   input wire logic sharedInputRight,
   output logic [1:0] sharedInputEn,
   // internal sources
   input wire logic timeoutClockEn,
   input wire logic masterClockRun,
   input wire logic pllLock,
   input wire logic tempOk,
   input wire logic readbackSerialOut,
   input wire logic micDetect,
   input wire logic micShort,
   // audio interface tristate and interrupt
   output logic pinTristateAll,
   output logic irq
);
   localparam int TW = $clog2(DEB_TICK_CYC + 1);
   localparam int DW = $clog2(DEB_TICKS + 1);
   localparam int CW = $clog2(OUT_CLK_DIV + 1);
   localparam int NP = mfpc_pkg::NPIN;
   localparam int ND = mfpc_pkg::NDED;

   logic [15:0] audioIfCtrl_q;
   logic [15:0] pinCtrlAb_q;
   logic [7:0] pinCtrlC_q;
   logic [7:0] sharedCtrl_q;
   logic [7:0] inputPol_q;
   logic [NP-1:0] irqStatus_q;
   logic [NP-1:0] irqMask_q;
   logic [NP-1:0] pinLevel;

   // ---- bus slave ----
   logic wrPend_q;
   logic rdPend_q;
   logic [mfpc_pkg::REG_IDX_W-1:0] idx_q;
   logic addrOk_q;
   logic take;
   logic [31:0] rdData;
   logic [NP-1:0] w1c;

   assign take = hsel && hready && (htrans == mfpc_pkg::HTRANS_NONSEQ);

   always_ff @(posedge clk) begin
      if (srst) begin
         wrPend_q <= 1'b0;
         rdPend_q <= 1'b0;
         idx_q <= '0;
         addrOk_q <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end else begin
         wrPend_q <= take && hwrite;
         if (take) begin
            idx_q <= haddr[mfpc_pkg::REG_IDX_W+1:2];
            addrOk_q <= (haddr[31:mfpc_pkg::REG_IDX_W+2] == '0);
         end
         // reads wait one cycle so a preceding write is visible
         if (take && !hwrite) begin
            rdPend_q <= 1'b1;
            hreadyout <= 1'b0;
         end else if (rdPend_q) begin
            rdPend_q <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= rdData;
         end
      end
   end

   logic wrOk;
   assign wrOk = wrPend_q && addrOk_q;

   always_comb begin
      rdData = 32'h00000000;
      if (addrOk_q) begin
         unique case (idx_q)
            mfpc_pkg::IDX_AUDIO_IF_CTRL: rdData[15:0] = audioIfCtrl_q;
            mfpc_pkg::IDX_PIN_CTRL_AB: rdData[15:0] = pinCtrlAb_q;
            mfpc_pkg::IDX_PIN_CTRL_C: rdData[7:0] = pinCtrlC_q;
            mfpc_pkg::IDX_SHARED_CTRL: rdData[7:0] = sharedCtrl_q;
            mfpc_pkg::IDX_INPUT_POL: rdData[7:0] = inputPol_q;
            mfpc_pkg::IDX_IRQ_STATUS: begin
               rdData[NP-1:0] = irqStatus_q;
               rdData[mfpc_pkg::STAT_LVL_LSB +: NP] = pinLevel;
            end
            mfpc_pkg::IDX_IRQ_MASK: rdData[NP-1:0] = irqMask_q;
            default: rdData = 32'h00000000;
         endcase
      end
   end

   // ---- control registers ----
   always_ff @(posedge clk) begin
      if (srst) begin
         audioIfCtrl_q <= mfpc_pkg::RST_AUDIO_IF;
         pinCtrlAb_q <= mfpc_pkg::RST_PIN_AB;
         pinCtrlC_q <= mfpc_pkg::RST_PIN_C;
         sharedCtrl_q <= mfpc_pkg::RST_SHARED;
         inputPol_q <= mfpc_pkg::RST_POL;
         irqMask_q <= '0;
      end else if (wrOk) begin
         unique case (idx_q)
            mfpc_pkg::IDX_AUDIO_IF_CTRL: audioIfCtrl_q <= hwdata[15:0];
            mfpc_pkg::IDX_PIN_CTRL_AB: pinCtrlAb_q <= hwdata[15:0];
            mfpc_pkg::IDX_PIN_CTRL_C: pinCtrlC_q <= hwdata[7:0];
            mfpc_pkg::IDX_SHARED_CTRL: sharedCtrl_q <= hwdata[7:0] & mfpc_pkg::SHARED_USED;
            mfpc_pkg::IDX_INPUT_POL: inputPol_q <= hwdata[7:0] & mfpc_pkg::POL_USED;
            mfpc_pkg::IDX_IRQ_MASK: irqMask_q <= hwdata[NP-1:0];
            default: ;
         endcase
      end
   end

   // ---- per-pin fields: a, b, c, left, right ----
   logic [7:0] ded [ND];
   logic [NP-1:0] debEn;
   logic [NP-1:0] irqEn;
   logic [NP-1:0] polInv;
   logic [1:0] shEn;

   assign ded[0] = pinCtrlAb_q[7:0];
   assign ded[1] = pinCtrlAb_q[mfpc_pkg::PIN_B_LSB +: 8];
   assign ded[2] = pinCtrlC_q;
   assign shEn = {sharedCtrl_q[mfpc_pkg::SH_R_EN], sharedCtrl_q[mfpc_pkg::SH_L_EN]};
   assign debEn = {sharedCtrl_q[mfpc_pkg::SH_R_DEB], sharedCtrl_q[mfpc_pkg::SH_L_DEB],
                   ded[2][mfpc_pkg::F_DEB], ded[1][mfpc_pkg::F_DEB], ded[0][mfpc_pkg::F_DEB]};
   assign irqEn = {sharedCtrl_q[mfpc_pkg::SH_R_IRQ], sharedCtrl_q[mfpc_pkg::SH_L_IRQ],
                   ded[2][mfpc_pkg::F_IRQ], ded[1][mfpc_pkg::F_IRQ], ded[0][mfpc_pkg::F_IRQ]};
   assign polInv = {inputPol_q[mfpc_pkg::POL_R], inputPol_q[mfpc_pkg::POL_L],
                    inputPol_q[mfpc_pkg::POL_A +: ND]};

   // ---- input synchronisers ----
   logic [NP-1:0] sync1_q;
   logic [NP-1:0] sync2_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {sharedInputRight, sharedInputLeft, multiPinIn};
         sync2_q <= sync1_q;
      end
   end

   // polarity first, shared pins read zero unless enabled
   logic [NP-1:0] rawLevel;
   assign rawLevel = (sync2_q ^ polInv) & {shEn, {ND{1'b1}}};

   // ---- debounce tick ----
   logic [TW-1:0] tickCnt_q;
   logic tick_q;
   logic debRun;
   assign debRun = timeoutClockEn && masterClockRun;
   always_ff @(posedge clk) begin
      if (srst) begin
         tickCnt_q <= '0;
         tick_q <= 1'b0;
      end else if (!debRun) begin
         tickCnt_q <= '0;
         tick_q <= 1'b0;
      end else if (tickCnt_q == TW'(DEB_TICK_CYC - 1)) begin
         tickCnt_q <= '0;
         tick_q <= 1'b1;
      end else begin
         tickCnt_q <= tickCnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // ---- debounce and event detect per pin ----
   logic [NP-1:0] prevLevel_q;
   logic [NP-1:0] event_w;
   for (genvar i = 0; i < NP; i++) begin : gDeb
      logic [DW-1:0] stab_q;
      logic deb_q;
      always_ff @(posedge clk) begin
         if (srst) begin
            stab_q <= '0;
            deb_q <= 1'b0;
         end else if (!debEn[i]) begin
            stab_q <= '0;
            deb_q <= rawLevel[i];
         end else if (rawLevel[i] == deb_q) begin
            stab_q <= '0;
         end else if (tick_q) begin
            if (stab_q == DW'(DEB_TICKS - 1)) begin
               stab_q <= '0;
               deb_q <= rawLevel[i];
            end else begin
               stab_q <= stab_q + 1'b1;
            end
         end
      end
      assign pinLevel[i] = deb_q;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prevLevel_q <= '0;
      end else begin
         prevLevel_q <= pinLevel;
      end
   end
   assign event_w = (pinLevel ^ prevLevel_q) & irqEn;

   // ---- interrupt status: set wins over write-one clear ----
   assign w1c = (wrOk && idx_q == mfpc_pkg::IDX_IRQ_STATUS) ? hwdata[NP-1:0] : '0;
   always_ff @(posedge clk) begin
      if (srst) begin
         irqStatus_q <= '0;
         irq <= 1'b0;
      end else begin
         irqStatus_q <= (irqStatus_q & ~w1c) | event_w;
         irq <= |(((irqStatus_q & ~w1c) | event_w) & irqMask_q);
      end
   end

   // ---- divided clock source ----
   logic [CW-1:0] divCnt_q;
   logic divClk_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         divCnt_q <= '0;
         divClk_q <= 1'b0;
      end else if (divCnt_q == CW'(OUT_CLK_DIV / 2 - 1)) begin
         divCnt_q <= '0;
         divClk_q <= ~divClk_q;
      end else begin
         divCnt_q <= divCnt_q + 1'b1;
      end
   end

   // ---- pin drive resolution ----
   logic tris;
   assign tris = audioIfCtrl_q[mfpc_pkg::TRIS_BIT];

   always_ff @(posedge clk) begin
      if (srst) begin
         pinTristateAll <= 1'b0;
         sharedInputEn <= '0;
      end else begin
         pinTristateAll <= tris;
         sharedInputEn <= shEn & {2{~tris}};
      end
   end

   for (genvar p = 0; p < ND; p++) begin : gDrv
      logic pu;
      logic pd;
      logic drv;
      logic val;
      assign pu = ded[p][mfpc_pkg::F_PU];
      assign pd = ded[p][mfpc_pkg::F_PD];
      always_comb begin
         drv = 1'b1;
         val = 1'b0;
         unique case (ded[p][3:0])
            mfpc_pkg::FN_INPUT: drv = 1'b0;
            mfpc_pkg::FN_CLOCK: val = divClk_q;
            mfpc_pkg::FN_LOW: val = 1'b0;
            mfpc_pkg::FN_HIGH: val = 1'b1;
            mfpc_pkg::FN_PLL_LOCK: val = pllLock;
            mfpc_pkg::FN_TEMP_OK: val = tempOk;
            mfpc_pkg::FN_READBACK: val = readbackSerialOut;
            mfpc_pkg::FN_IRQ: val = irq;
            mfpc_pkg::FN_MIC_DET: val = micDetect;
            mfpc_pkg::FN_MIC_SHORT: val = micShort;
            default: drv = 1'b0;
         endcase
      end
      always_ff @(posedge clk) begin
         if (srst) begin
            multiPinOe[p] <= 1'b0;
            multiPinOut[p] <= 1'b0;
            pinPullupEn[p] <= 1'b0;
            pinPulldownEn[p] <= 1'b0;
         end else begin
            pinPullupEn[p] <= pu;
            pinPulldownEn[p] <= pd;
            if (pu || pd) begin
               multiPinOe[p] <= 1'b0;
               multiPinOut[p] <= 1'b0;
            end else if (tris) begin
               multiPinOe[p] <= 1'b0;
               multiPinOut[p] <= 1'b0;
            end else begin
               multiPinOe[p] <= drv;
               multiPinOut[p] <= val;
            end
         end
      end
   end
endmodule : mfpc_pin_control

// File: verif/mfpc_pin_control_sva.sv
// assertion checker for the pin control block
`timescale 1ns/100ps
module mfpc_sva (
   // clock and bus
   input wire logic clk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // pins
   input wire logic [2:0] multiPinOe,
   input wire logic [2:0] pinPullupEn,
   input wire logic [2:0] pinPulldownEn,
   input wire logic [1:0] sharedInputEn,
   input wire logic pinTristateAll,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wire logic [2:0] pulls = pinPullupEn | pinPulldownEn;
   sequence s_rd; hsel && hready && htrans == 2'h2 && !hwrite; endsequence
   sequence s_wr; hsel && hready && htrans == 2'h2 && hwrite; endsequence
   sequence s_wait; !hreadyout ##1 hreadyout; endsequence
   property p_read; s_rd |=> s_wait; endproperty
   property p_write; s_wr |=> hreadyout; endproperty
   property p_okay; hresp == 1'b0; endproperty
   property p_one_wait; !hreadyout |=> hreadyout; endproperty
   property p_release;
      $fell(srst) |-> ##[0:1] (pinPulldownEn == 3'h7 && pinPullupEn == 3'h0
         && multiPinOe == 3'h0 && !irq && !pinTristateAll);
   endproperty
   property p_pull_wins; (pulls & $past(pulls) & multiPinOe) == 3'h0; endproperty
   property p_tris_oe; pinTristateAll && $past(pinTristateAll) |-> multiPinOe == 3'h0; endproperty
   property p_tris_sh; pinTristateAll && $past(pinTristateAll) |-> sharedInputEn == 2'h0; endproperty
   a_read: assert property (p_read) else $error("read wait not one cycle");
   a_write: assert property (p_write) else $error("write not zero wait");
   a_okay: assert property (p_okay) else $error("response not okay");
   a_one_wait: assert property (p_one_wait) else $error("ready low too long");
   a_release: assert property (p_release) else $error("bad state after reset");
   a_pull_wins: assert property (p_pull_wins) else $error("pin driven with pull on");
   a_tris_oe: assert property (p_tris_oe) else $error("pin driven in tristate");
   a_tris_sh: assert property (p_tris_sh) else $error("shared enabled in tristate");
endmodule : mfpc_sva

bind mfpc_pin_control mfpc_sva u_sva (.clk(clk), .srst(srst), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .multiPinOe(multiPinOe), .pinPullupEn(pinPullupEn), .pinPulldownEn(pinPulldownEn),
   .sharedInputEn(sharedInputEn), .pinTristateAll(pinTristateAll), .irq(irq));

// File: verif/mfpc_button_model.sv
// buttons at the dedicated and shared pins, pull-ups at the dedicated pins only
`timescale 1ns/100ps
module mfpc_button_model (
   // from the block
   input wire logic [2:0] multiPinOut,
   input wire logic [2:0] multiPinOe,
   input wire logic [2:0] pinPullupEn,
   // from the bench
   input wire logic [4:0] btnClosed,
   // to the block
   output logic [2:0] multiPinIn,
   output logic sharedInputLeft,
   output logic sharedInputRight
);
   // driven pin wins, closed button ties high, else pull level
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         multiPinIn[i] = multiPinOe[i] ? multiPinOut[i] : (btnClosed[i] | pinPullupEn[i]);
      end
   end
   assign sharedInputLeft = btnClosed[3];
   assign sharedInputRight = btnClosed[4];
endmodule : mfpc_button_model

// File: verif/mfpc_pin_control_tb_top.sv
// self-checking bench for the pin control block
`timescale 1ns/100ps
module mfpc_pin_control_tb_top;
   localparam logic [5:0] AB = mfpc_pkg::IDX_PIN_CTRL_AB;
   localparam logic [5:0] PC = mfpc_pkg::IDX_PIN_CTRL_C;
   localparam logic [5:0] SH = mfpc_pkg::IDX_SHARED_CTRL;
   localparam logic [5:0] ST = mfpc_pkg::IDX_IRQ_STATUS;
   localparam logic [5:0] MK = mfpc_pkg::IDX_IRQ_MASK;
   localparam logic [5:0] POL = mfpc_pkg::IDX_INPUT_POL;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [4:0] src = 5'h15;
   logic [1:0] run = 2'h3;
   logic [4:0] btn = 5'h00;
   logic [31:0] rd;
   wire logic hreadyout, hresp, irq, tris, shL, shR;
   wire logic [31:0] hrdata;
   wire logic [2:0] pin, pOut, pOe, pu, pd;
   wire logic [1:0] shEn;
   int errCount = 0;
   int samplesChecked = 0;
   int cyc = 0;

   mfpc_pin_control #(.DEB_TICK_CYC(4), .DEB_TICKS(4), .OUT_CLK_DIV(4)) dut (.clk(clk),
      .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .multiPinIn(pin), .multiPinOut(pOut), .multiPinOe(pOe),
      .pinPullupEn(pu), .pinPulldownEn(pd), .sharedInputLeft(shL), .sharedInputRight(shR),
      .sharedInputEn(shEn), .timeoutClockEn(run[0]), .masterClockRun(run[1]),
      .pllLock(src[0]), .tempOk(src[1]), .readbackSerialOut(src[2]), .micDetect(src[3]),
      .micShort(src[4]), .pinTristateAll(tris), .irq(irq));
   mfpc_button_model u_btn (.multiPinOut(pOut), .multiPinOe(pOe), .pinPullupEn(pu),
      .btnClosed(btn), .multiPinIn(pin), .sharedInputLeft(shL), .sharedInputRight(shR));

   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         errCount++;
         finalReport();
      end
   end

   task automatic finalReport();
      $display("mismatches %0d of %0d checks", errCount, samplesChecked);
      if (errCount == 0 && samplesChecked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finalReport

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samplesChecked++;
      if (g !== e) begin
         errCount++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one single transfer; called just after a rising edge
   task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] wd);
      logic r;
      hsel <= 1'b1;
      haddr <= {24'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      do begin
         @(negedge clk);
         r = hreadyout;
         @(posedge clk);
      end while (r !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(negedge clk);
         r = hreadyout;
         rd = hrdata;
         @(posedge clk);
      end while (r !== 1'b1);
   endtask : bus

   task automatic expectReg(input string nm, input logic [5:0] idx, input logic [31:0] e);
      bus(1'b0, idx, 32'h0);
      chk(nm, e, rd);
   endtask : expectReg

   task automatic pinsAfter(input logic [2:0] eOe, input logic [2:0] eOut, input logic [2:0] m);
      @(posedge clk);
      @(negedge clk);
      chk("pin enable", {29'h0, eOe}, {29'h0, pOe});
      chk("pin level", {29'h0, eOut & m}, {29'h0, pOut & m});
      @(posedge clk);
   endtask : pinsAfter

   // counts changes of pin a over eight cycles
   task automatic chkClockOut();
      int n;
      logic last;
      n = 0;
      @(negedge clk);
      last = pOut[0];
      repeat (8) begin
         @(negedge clk);
         if (pOut[0] !== last) begin
            n++;
         end
         last = pOut[0];
      end
      chk("clock toggles", 32'h4, 32'(n));
      @(posedge clk);
   endtask : chkClockOut

   task automatic waitIrq(input logic e);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (irq !== e && n < 60);
      chk("irq", {31'h0, e}, {31'h0, irq});
      @(posedge clk);
   endtask : waitIrq

   task automatic tResetValues();
      @(negedge clk);
      chk("pulls", 32'h38, {26'h0, pd, pu});
      chk("reset outputs", 32'h0, {25'h0, pOe, shEn, tris, irq});
      @(posedge clk);
      expectReg("pin ab", AB, 32'h1010);
      expectReg("pin c", PC, 32'h10);
      expectReg("shared", SH, 32'h0);
      expectReg("polarity", POL, 32'h0);
      expectReg("unmapped", 6'h3F, 32'h0);
   endtask : tResetValues

   task automatic tFunctions();
      logic [15:0] oeTab;
      logic [15:0] outTab;
      oeTab = 16'h03FE;
      outTab = 16'h0258;
      for (int c = 0; c < 16; c++) begin
         bus(1'b1, AB, {28'h0, 4'(c)});
         pinsAfter({2'h0, oeTab[c]}, {2'h0, outTab[c]}, (c == 1) ? 3'h0 : 3'h1);
         if (c == 1) begin
            chkClockOut();
         end
      end
      bus(1'b1, AB, 32'h0302);
      bus(1'b1, PC, 32'h03);
      pinsAfter(3'h7, 3'h6, 3'h7);
      expectReg("pin ab", AB, 32'h0302);
   endtask : tFunctions

   task automatic tPrecedence();
      bus(1'b1, PC, 32'h23);
      pinsAfter(3'h3, 3'h2, 3'h3);
      chk("pull up", 32'h4, {29'h0, pu});
      bus(1'b1, SH, 32'h11);
      bus(1'b1, mfpc_pkg::IDX_AUDIO_IF_CTRL, 32'h2000);
      pinsAfter(3'h0, 3'h0, 3'h0);
      chk("tristate", 32'h1, {29'h0, shEn, tris});
      bus(1'b1, mfpc_pkg::IDX_AUDIO_IF_CTRL, 32'h0);
      pinsAfter(3'h3, 3'h2, 3'h3);
      chk("shared en", 32'h6, {29'h0, shEn, tris});
   endtask : tPrecedence

   task automatic tInputIrq();
      bus(1'b1, SH, 32'h0);
      bus(1'b1, AB, 32'h0040);
      bus(1'b1, MK, 32'h1F);
      bus(1'b1, ST, 32'h1F);
      bus(1'b1, POL, 32'h04);
      waitIrq(1'b1);
      expectReg("status", ST, 32'h0501);
      bus(1'b1, ST, 32'h1);
      waitIrq(1'b0);
      bus(1'b1, MK, 32'h0);
      btn <= 5'h01;
      repeat (20) @(posedge clk);
      expectReg("status", ST, 32'h0401);
      waitIrq(1'b0);
      bus(1'b1, MK, 32'h1);
      waitIrq(1'b1);
      bus(1'b1, ST, 32'h1);
      waitIrq(1'b0);
      bus(1'b1, AB, 32'h0);
      btn <= 5'h00;
      repeat (20) @(posedge clk);
      expectReg("status", ST, 32'h0500);
      bus(1'b1, SH, 32'h05);
      bus(1'b1, MK, 32'h1F);
      btn <= 5'h08;
      waitIrq(1'b1);
      expectReg("status", ST, 32'h0D08);
      btn <= 5'h00;
      repeat (20) @(posedge clk);
      bus(1'b1, ST, 32'h1F);
   endtask : tInputIrq

   task automatic tDebounce();
      bus(1'b1, AB, 32'h00C0);
      repeat (40) @(posedge clk);
      bus(1'b1, ST, 32'h1F);
      btn <= 5'h01;
      repeat (3) @(posedge clk);
      btn <= 5'h00;
      repeat (40) @(posedge clk);
      expectReg("status", ST, 32'h0500);
      run <= 2'h1;
      btn <= 5'h01;
      repeat (40) @(posedge clk);
      expectReg("status", ST, 32'h0500);
      run <= 2'h3;
      waitIrq(1'b1);
   endtask : tDebounce

   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      tResetValues();
      tFunctions();
      tPrecedence();
      tInputIrq();
      tDebounce();
      finalReport();
   end
endmodule : mfpc_pin_control_tb_top
